//--- inc/can_filt_pkg.sv
`default_nettype none
package can_filt_pkg;
   localparam int NUM_FILT = 16;
   localparam int NUM_MASK = 3;
   localparam int REG_W = 16;
   localparam int APB_AW = 12;
   localparam int SID_W = 11;
   localparam int EID_W = 18;

   // byte addresses, one 32-bit word per register
   localparam logic [11:0] OFS_BPTR0 = 12'h000;
   localparam logic [11:0] OFS_MSEL_LO = 12'h010;
   localparam logic [11:0] OFS_MSEL_HI = 12'h014;
   localparam logic [11:0] OFS_FEN = 12'h018;
   localparam logic [11:0] OFS_STAT = 12'h01c;
   localparam logic [11:0] OFS_MASK0 = 12'h020;
   localparam logic [11:0] OFS_MASK_END = 12'h038;
   localparam logic [11:0] OFS_CNT = 12'h03c;
   localparam logic [11:0] OFS_FILT0 = 12'h040;
   localparam logic [11:0] OFS_FILT_END = 12'h0c0;

   // identifier register layout
   localparam int SID_MSB = 15;
   localparam int SID_LSB = 5;
   localparam int FTYPE_BIT = 3;
   localparam int EIDHI_MSB = 1;
   localparam int EIDHI_LSB = 0;
   localparam logic [15:0] SID_WMASK = 16'hffeb;
   localparam logic [15:0] FULL_WMASK = 16'hffff;

   // field widths of the packed select registers
   localparam int BPTR_W = 4;
   localparam int BPTR_PER_REG = 4;
   localparam int MSEL_W = 2;
   localparam int MSEL_PER_REG = 8;

   // reset values
   localparam logic [15:0] ID_RST = 16'h0000;
   localparam logic [15:0] BPTR_RST = 16'h0000;
   localparam logic [15:0] MSEL_RST = 16'h0000;
   localparam logic [15:0] FEN_RST = 16'hffff;

   // codes
   localparam logic [3:0] BUF_FIFO = 4'hf;
   localparam logic [1:0] MSEL_RSVD = 2'h3;

   // status register layout
   localparam int STAT_ACC_BIT = 15;
   localparam int STAT_SEEN_BIT = 14;
   localparam int STAT_RSVD_BIT = 13;
   localparam int STAT_FILT_LSB = 4;
   localparam int STAT_BUF_LSB = 0;
endpackage
`default_nettype wire

//--- logic/filter_compare.sv
`default_nettype none
module filter_compare
   import can_filt_pkg::*;
(
   // stored filter and selected mask
   input wire logic [15:0] filt_sid_i,
   input wire logic [15:0] filt_eid_i,
   input wire logic [15:0] mask_sid_i,
   input wire logic [15:0] mask_eid_i,
   // incoming message
   input wire logic msg_ide_i,
   input wire logic [SID_W-1:0] msg_sid_i,
   input wire logic [EID_W-1:0] msg_eid_i,
   // result
   output logic match_o
);
   logic [SID_W-1:0] f_sid;
   logic [SID_W-1:0] m_sid;
   logic [EID_W-1:0] f_eid;
   logic [EID_W-1:0] m_eid;
   logic sid_ok;
   logic eid_ok;
   logic type_ok;

   assign f_sid = filt_sid_i[SID_MSB:SID_LSB];
   assign m_sid = mask_sid_i[SID_MSB:SID_LSB];
   assign f_eid = {filt_sid_i[EIDHI_MSB:EIDHI_LSB], filt_eid_i};
   assign m_eid = {mask_sid_i[EIDHI_MSB:EIDHI_LSB], mask_eid_i};
   // exact bit equality where mask bit set, don't care elsewhere
   assign sid_ok = ((msg_sid_i ^ f_sid) & m_sid) == '0;
   assign eid_ok = ((msg_eid_i ^ f_eid) & m_eid) == '0;
   // frame type only checked when the mask asks for it
   assign type_ok = !mask_sid_i[FTYPE_BIT] || (filt_sid_i[FTYPE_BIT] == msg_ide_i);
   // standard frames carry no extended bits to compare
   assign match_o = type_ok && sid_ok && (!msg_ide_i || eid_ok);
endmodule
`default_nettype wire

//--- logic/can_rx_acceptance_filter.sv
`default_nettype none
module can_rx_acceptance_filter
   import can_filt_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [APB_AW-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // message from protocol engine
   input wire logic msg_valid_i,
   input wire logic msg_ide_i,
   input wire logic [SID_W-1:0] msg_sid_i,
   input wire logic [EID_W-1:0] msg_eid_i,
   // acceptance result
   output logic hit_valid_o,
   output logic hit_accept_o,
   output logic [3:0] hit_filter_o,
   output logic [3:0] hit_buffer_o,
   output logic hit_fifo_o
);
   typedef struct packed {
      logic [NUM_FILT-1:0][15:0] fsid;
      logic [NUM_FILT-1:0][15:0] feid;
      logic [NUM_MASK-1:0][15:0] msid;
      logic [NUM_MASK-1:0][15:0] meid;
      logic [3:0][15:0] bptr;
      logic [1:0][15:0] msel;
      logic [15:0] fen;
      logic [15:0] stat;
      logic [15:0] acc_cnt;
      logic [15:0] rej_cnt;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic hit_valid;
      logic hit_accept;
      logic [3:0] hit_filter;
      logic [3:0] hit_buffer;
      logic hit_fifo;
   } state_type;

   state_type s_r;
   state_type s_nxt;

   logic [NUM_FILT-1:0][15:0] sel_msid;
   logic [NUM_FILT-1:0][15:0] sel_meid;
   logic [NUM_FILT-1:0] match;

   // pointer field of filter n
   function automatic logic [3:0] bptr_of(input logic [3:0][15:0] regs, input int n);
      logic [15:0] r;
      r = regs[n / BPTR_PER_REG];
      return r[(n % BPTR_PER_REG) * BPTR_W +: BPTR_W];
   endfunction

   // mask source field of filter n
   function automatic logic [1:0] msel_of(input logic [1:0][15:0] regs, input int n);
      logic [15:0] r;
      r = regs[n / MSEL_PER_REG];
      return r[(n % MSEL_PER_REG) * MSEL_W +: MSEL_W];
   endfunction

   // byte-lane merge restricted to writable bits
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                         input logic [3:0] strb, input logic [15:0] wm);
      logic [15:0] m;
      m = {{8{strb[1]}}, {8{strb[0]}}} & wm;
      return (old & ~m) | (wd[15:0] & m);
   endfunction

   function automatic logic addr_mapped(input logic [APB_AW-1:0] a);
      logic ok;
      ok = (a < OFS_MASK_END) || (a == OFS_CNT) || ((a >= OFS_FILT0) && (a < OFS_FILT_END));
      return ok && (a[1:0] == 2'h0);
   endfunction

   // mask registers routed to each filter by its source field
   always_comb begin
      for (int i = 0; i < NUM_FILT; i++) begin
         sel_msid[i] = '0;
         sel_meid[i] = '0;
         if (msel_of(s_r.msel, i) != MSEL_RSVD) begin
            sel_msid[i] = s_r.msid[msel_of(s_r.msel, i)];
            sel_meid[i] = s_r.meid[msel_of(s_r.msel, i)];
         end
      end
   end

   for (genvar g = 0; g < NUM_FILT; g++) begin : g_filt
      filter_compare u_cmp (
         .filt_sid_i(s_r.fsid[g]),
         .filt_eid_i(s_r.feid[g]),
         .mask_sid_i(sel_msid[g]),
         .mask_eid_i(sel_meid[g]),
         .msg_ide_i(msg_ide_i),
         .msg_sid_i(msg_sid_i),
         .msg_eid_i(msg_eid_i),
         .match_o(match[g])
      );
   end

   always_comb begin
      logic setup;
      logic done;
      logic found;
      logic rsvd_hit;
      logic [3:0] win;
      logic [15:0] rd;
      logic [APB_AW-1:0] a;
      logic [APB_AW-1:0] rel;
      int idx;
      setup = psel_i && !penable_i;
      done = psel_i && penable_i && s_r.pready;
      found = 1'b0;
      rsvd_hit = 1'b0;
      win = 4'h0;
      rd = 16'h0000;
      a = paddr_i;
      rel = '0;
      idx = 0;
      s_nxt = s_r;
      s_nxt.pready = 1'b0;
      s_nxt.pslverr = 1'b0;
      s_nxt.prdata = 32'h0000_0000;
      s_nxt.hit_valid = 1'b0;

      // register read, answered in the access phase
      if (a >= OFS_FILT0) begin
         rel = a - OFS_FILT0;
         idx = int'(rel[6:3]);
         rd = rel[2] ? s_r.feid[idx] : s_r.fsid[idx];
      end else if (a >= OFS_MASK0 && a < OFS_MASK_END) begin
         rel = a - OFS_MASK0;
         idx = int'(rel[4:3]);
         rd = rel[2] ? s_r.meid[idx] : s_r.msid[idx];
      end else begin
         case (a)
            OFS_BPTR0: rd = s_r.bptr[0];
            OFS_BPTR0 + 12'h004: rd = s_r.bptr[1];
            OFS_BPTR0 + 12'h008: rd = s_r.bptr[2];
            OFS_BPTR0 + 12'h00c: rd = s_r.bptr[3];
            OFS_MSEL_LO: rd = s_r.msel[0];
            OFS_MSEL_HI: rd = s_r.msel[1];
            OFS_FEN: rd = s_r.fen;
            OFS_STAT: rd = s_r.stat;
            default: rd = 16'h0000;
         endcase
      end
      if (setup) begin
         s_nxt.pready = 1'b1;
         s_nxt.pslverr = !addr_mapped(a);
         s_nxt.prdata = 32'h0000_0000;
         if (addr_mapped(a) && !pwrite_i) begin
            if (a == OFS_CNT) begin
               s_nxt.prdata = {s_r.rej_cnt, s_r.acc_cnt};
            end else begin
               s_nxt.prdata = {16'h0000, rd};
            end
         end
      end

      // acceptance: scan from the top so the lowest match wins
      for (int i = NUM_FILT - 1; i >= 0; i--) begin
         if (s_r.fen[i] && match[i] && msel_of(s_r.msel, i) != MSEL_RSVD) begin
            found = 1'b1;
            win = 4'(i);
         end
         if (s_r.fen[i] && msel_of(s_r.msel, i) == MSEL_RSVD) begin
            rsvd_hit = 1'b1;
         end
      end
      if (msg_valid_i) begin
         s_nxt.hit_valid = 1'b1;
         s_nxt.hit_accept = found;
         s_nxt.hit_filter = win;
         s_nxt.hit_buffer = found ? bptr_of(s_r.bptr, int'(win)) : 4'h0;
         s_nxt.hit_fifo = found && (bptr_of(s_r.bptr, int'(win)) == BUF_FIFO);
         s_nxt.stat = 16'h0000;
         s_nxt.stat[STAT_ACC_BIT] = found;
         s_nxt.stat[STAT_SEEN_BIT] = 1'b1;
         s_nxt.stat[STAT_RSVD_BIT] = rsvd_hit;
         s_nxt.stat[STAT_FILT_LSB +: 4] = win;
         s_nxt.stat[STAT_BUF_LSB +: 4] = found ? bptr_of(s_r.bptr, int'(win)) : 4'h0;
         if (found) begin
            s_nxt.acc_cnt = s_r.acc_cnt + 16'h0001;
         end else begin
            s_nxt.rej_cnt = s_r.rej_cnt + 16'h0001;
         end
      end

      // register write at the completing edge
      if (done && pwrite_i && !s_r.pslverr) begin
         if (a >= OFS_FILT0) begin
            rel = a - OFS_FILT0;
            idx = int'(rel[6:3]);
            if (rel[2]) begin
               s_nxt.feid[idx] = merge(s_r.feid[idx], pwdata_i, pstrb_i, FULL_WMASK);
            end else begin
               s_nxt.fsid[idx] = merge(s_r.fsid[idx], pwdata_i, pstrb_i, SID_WMASK);
            end
         end else if (a >= OFS_MASK0 && a < OFS_MASK_END) begin
            rel = a - OFS_MASK0;
            idx = int'(rel[4:3]);
            if (rel[2]) begin
               s_nxt.meid[idx] = merge(s_r.meid[idx], pwdata_i, pstrb_i, FULL_WMASK);
            end else begin
               s_nxt.msid[idx] = merge(s_r.msid[idx], pwdata_i, pstrb_i, SID_WMASK);
            end
         end else begin
            case (a)
               OFS_BPTR0: s_nxt.bptr[0] = merge(s_r.bptr[0], pwdata_i, pstrb_i, FULL_WMASK);
               OFS_BPTR0 + 12'h004: begin
                  s_nxt.bptr[1] = merge(s_r.bptr[1], pwdata_i, pstrb_i, FULL_WMASK);
               end
               OFS_BPTR0 + 12'h008: begin
                  s_nxt.bptr[2] = merge(s_r.bptr[2], pwdata_i, pstrb_i, FULL_WMASK);
               end
               OFS_BPTR0 + 12'h00c: begin
                  s_nxt.bptr[3] = merge(s_r.bptr[3], pwdata_i, pstrb_i, FULL_WMASK);
               end
               OFS_MSEL_LO: s_nxt.msel[0] = merge(s_r.msel[0], pwdata_i, pstrb_i, FULL_WMASK);
               OFS_MSEL_HI: s_nxt.msel[1] = merge(s_r.msel[1], pwdata_i, pstrb_i, FULL_WMASK);
               OFS_FEN: s_nxt.fen = merge(s_r.fen, pwdata_i, pstrb_i, FULL_WMASK);
               // any write clears both counters; a count in the same cycle is dropped
               OFS_CNT: begin
                  s_nxt.acc_cnt = 16'h0000;
                  s_nxt.rej_cnt = 16'h0000;
               end
               default: s_nxt.stat = s_nxt.stat;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
         for (int i = 0; i < NUM_FILT; i++) begin
            s_r.fsid[i] <= ID_RST;
            s_r.feid[i] <= ID_RST;
         end
         for (int m = 0; m < NUM_MASK; m++) begin
            s_r.msid[m] <= ID_RST;
            s_r.meid[m] <= ID_RST;
         end
         for (int g = 0; g < 4; g++) begin
            s_r.bptr[g] <= BPTR_RST;
         end
         s_r.msel[0] <= MSEL_RST;
         s_r.msel[1] <= MSEL_RST;
         s_r.fen <= FEN_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata_o = s_r.prdata;
   assign pready_o = s_r.pready;
   assign pslverr_o = s_r.pslverr;
   assign hit_valid_o = s_r.hit_valid;
   assign hit_accept_o = s_r.hit_accept;
   assign hit_filter_o = s_r.hit_filter;
   assign hit_buffer_o = s_r.hit_buffer;
   assign hit_fifo_o = s_r.hit_fifo;
endmodule
`default_nettype wire

//--- test/can_filt_monitor.sv
`default_nettype none
module can_filt_monitor
   import can_filt_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // apb
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic [APB_AW-1:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // messages
   input wire logic msg_valid_i,
   input wire logic hit_valid_o,
   input wire logic hit_accept_o,
   input wire logic [3:0] hit_filter_o,
   input wire logic [3:0] hit_buffer_o,
   input wire logic hit_fifo_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_setup; psel_i && !penable_i; endsequence
   sequence s_access; psel_i && penable_i && pready_o; endsequence
   property p_zero_wait; s_setup |=> s_access; endproperty
   a_zero_wait: assert property (p_zero_wait)
      else $error("setup not answered next cycle");
   property p_ready_pulse; pready_o |=> !pready_o; endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("ready longer than one cycle");
   property p_err_align; s_setup ##0 (paddr_i[1:0] != 2'h0) |=> pslverr_o; endproperty
   a_err_align: assert property (p_err_align)
      else $error("unaligned access without error");
   property p_rdata_idle; !pready_o |-> prdata_o == 32'h0; endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data outside access");
   property p_hit_lat; msg_valid_i |=> hit_valid_o; endproperty
   a_hit_lat: assert property (p_hit_lat)
      else $error("no result one cycle after message");
   property p_hit_only; !msg_valid_i |=> !hit_valid_o; endproperty
   a_hit_only: assert property (p_hit_only)
      else $error("result without message");
   property p_fifo; hit_valid_o |-> hit_fifo_o == (hit_accept_o && hit_buffer_o == BUF_FIFO);
   endproperty
   a_fifo: assert property (p_fifo)
      else $error("fifo flag disagrees with pointer");
   property p_reject;
      hit_valid_o && !hit_accept_o |-> hit_filter_o == 4'h0 && hit_buffer_o == 4'h0;
   endproperty
   a_reject: assert property (p_reject)
      else $error("rejected message carries a destination");
   property p_hold;
      !hit_valid_o |-> $stable({hit_accept_o, hit_filter_o, hit_buffer_o});
   endproperty
   a_hold: assert property (p_hold)
      else $error("result changed between messages");
endmodule
`default_nettype wire

//--- test/can_engine_model.sv
`default_nettype none
module can_engine_model
   import can_filt_pkg::*;
(
   // clock
   input wire logic clk_i,
   // received identifier
   output logic msg_valid_o,
   output logic msg_ide_o,
   output logic [SID_W-1:0] msg_sid_o,
   output logic [EID_W-1:0] msg_eid_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      msg_valid_o = 1'b0;
      msg_ide_o = 1'b0;
      msg_sid_o = '0;
      msg_eid_o = '0;
   end
   // idle lines show the inverse of the last identifier
   task automatic send(input logic ide, input logic [SID_W-1:0] s, input logic [EID_W-1:0] e,
                       input logic [3:0] gap);
      repeat (gap) @(posedge clk_i);
      @(posedge clk_i);
      msg_valid_o <= 1'b1;
      msg_ide_o <= ide;
      msg_sid_o <= s;
      msg_eid_o <= e;
      @(posedge clk_i);
      msg_valid_o <= 1'b0;
      msg_ide_o <= ~ide;
      msg_sid_o <= ~s;
      msg_eid_o <= ~e;
   endtask
endmodule
`default_nettype wire

//--- test/testbench.sv
`default_nettype none
module testbench
   import can_filt_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [APB_AW-1:0] paddr_i = '0;
   logic [3:0] pstrb_i = 4'h3, st = 4'h3;
   logic [31:0] pwdata_i = '0, prdata_o, seed = 32'h12, fl;
   logic pready_o, pslverr_o, msg_valid_i, msg_ide_i, hit_valid_o, hit_accept_o, hit_fifo_o, ide;
   logic [SID_W-1:0] msg_sid_i, s;
   logic [EID_W-1:0] msg_eid_i, e;
   logic [3:0] hit_filter_o, hit_buffer_o, f, bptr[16];
   logic [15:0] fsid[16], feid[16], msid[3], meid[3], fen, w, ml, mh;
   logic [1:0] msel[16];
   logic [15:0] acc, rej;
   logic [9:0] h, hw;
   logic rsv;
   logic [32:0] rq[$];
   logic [9:0] hq[$];
   int n_fail = 0, tests_run = 0;
   can_rx_acceptance_filter can_rx_acceptance_filter_i(.clk_i(clk_i), .rst_i(rst_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .msg_valid_i(msg_valid_i), .msg_ide_i(msg_ide_i),
      .msg_sid_i(msg_sid_i), .msg_eid_i(msg_eid_i), .hit_valid_o(hit_valid_o),
      .hit_accept_o(hit_accept_o), .hit_filter_o(hit_filter_o), .hit_buffer_o(hit_buffer_o),
      .hit_fifo_o(hit_fifo_o));
   can_engine_model can_engine_model_i(.clk_i(clk_i), .msg_valid_o(msg_valid_i),
      .msg_ide_o(msg_ide_i), .msg_sid_o(msg_sid_i), .msg_eid_o(msg_eid_i));
   initial forever #2.5 clk_i = ~clk_i;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [9:0] ref_hit(input logic i, input logic [10:0] a,
                                          input logic [17:0] b);
      logic ok;
      for (int n = 0; n < NUM_FILT; n++) begin
         ok = fen[n] && msel[n] != MSEL_RSVD && ((a ^ fsid[n][15:5]) & msid[msel[n]][15:5]) == 0;
         if (i)
            ok = ok && (({b[17:16], b[15:0]} ^ {fsid[n][1:0], feid[n]})
                 & {msid[msel[n]][1:0], meid[msel[n]]}) == 0;
         if (msid[msel[n]][3] === 1'b1)
            ok = ok && fsid[n][3] == i;
         if (ok)
            return {1'b1, 4'(n), bptr[n], bptr[n] == BUF_FIFO};
      end
      return 10'h0;
   endfunction
   task automatic apb(input logic we, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] x);
      @(posedge clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= we;
      pstrb_i <= st;
      paddr_i <= a;
      pwdata_i <= d;
      rq.push_back(x);
      @(posedge clk_i);
      penable_i <= 1'b1;
      do @(posedge clk_i); while (pready_o !== 1'b1);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      apb(1'b1, a, {16'h0, d}, 33'h0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [15:0] d);
      apb(1'b0, a, 32'h0, {17'h0, d});
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge clk_i) begin
      if (pready_o === 1'b1) begin
         tests_run++;
         if ({pslverr_o, prdata_o} !== rq[0]) begin
            $display("ERROR apb %h exp %h got %h", paddr_i, rq[0], {pslverr_o, prdata_o});
            n_fail++;
         end
         void'(rq.pop_front());
      end
      if (hit_valid_o === 1'b1) begin
         tests_run++;
         hw = {hit_accept_o, hit_filter_o, hit_buffer_o, hit_fifo_o};
         if (hw !== hq[0]) begin
            $display("ERROR hit exp %h got %h", hq[0], hw);
            n_fail++;
         end
         void'(hq.pop_front());
      end
   end
   initial begin
      #50000;
      n_fail++;
      stop_test();
   end
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(OFS_FEN, FEN_RST);
      rd(OFS_MSEL_HI, MSEL_RST);
      rd(OFS_BPTR0 + 12'h00c, BPTR_RST);
      apb(1'b0, OFS_MASK_END, 32'h0, 33'h100000000);
      apb(1'b1, 12'h042, 32'h1, 33'h100000000);
      wr(OFS_FILT0, 16'hffff);
      rd(OFS_FILT0, SID_WMASK);
      st = 4'h1;
      wr(OFS_FILT0, 16'h0000);
      st = 4'h3;
      rd(OFS_FILT0, 16'hff00);
      $display("test reset done");
      for (int r = 0; r < 4; r++) begin
         for (int n = 0; n < NUM_FILT; n++) begin
            fsid[n] = 16'(rnd()) & SID_WMASK;
            feid[n] = 16'(rnd());
            msel[n] = 2'(rnd());
            bptr[n] = 4'(rnd());
            wr(OFS_FILT0 + 12'(8 * n), fsid[n]);
            wr(OFS_FILT0 + 12'(8 * n + 4), feid[n]);
         end
         for (int m = 0; m < NUM_MASK; m++) begin
            msid[m] = (r == 1) ? 16'h0 : 16'(rnd()) & SID_WMASK;
            meid[m] = (r == 1) ? 16'h0 : 16'(rnd());
            wr(OFS_MASK0 + 12'(8 * m), msid[m]);
            wr(OFS_MASK0 + 12'(8 * m + 4), meid[m]);
         end
         fen = (r > 1) ? 16'(rnd()) : FEN_RST;
         wr(OFS_FEN, fen);
         for (int g = 0; g < 4; g++) begin
            w = {bptr[4 * g + 3], bptr[4 * g + 2], bptr[4 * g + 1], bptr[4 * g]};
            wr(OFS_BPTR0 + 12'(4 * g), w);
            rd(OFS_BPTR0 + 12'(4 * g), w);
         end
         for (int k = 0; k < 8; k++) begin
            ml[2 * k +: 2] = msel[k];
            mh[2 * k +: 2] = msel[k + 8];
         end
         wr(OFS_MSEL_LO, ml);
         wr(OFS_MSEL_HI, mh);
         rd(OFS_MSEL_LO, ml);
         rd(OFS_MSEL_HI, mh);
         acc = 16'h0;
         rej = 16'h0;
         wr(OFS_CNT, 16'h0);
         rsv = 1'b0;
         for (int n = 0; n < NUM_FILT; n++)
            rsv = rsv | (fen[n] && msel[n] == MSEL_RSVD);
         for (int i = 0; i < 32; i++) begin
            f = 4'(rnd());
            fl = (i % 2 == 1) ? rnd() : 32'h0;
            s = fsid[f][15:5] ^ fl[10:0];
            e = {fsid[f][1:0], feid[f]} ^ fl[28:11];
            ide = fsid[f][3] ^ fl[31];
            h = ref_hit(ide, s, e);
            hq.push_back(h);
            acc = acc + 16'(h[9]);
            rej = rej + 16'(!h[9]);
            can_engine_model_i.send(ide, s, e, fl[3:0] & 4'h3);
         end
         apb(1'b0, OFS_CNT, 32'h0, {1'b0, rej, acc});
         rd(OFS_STAT, {h[9], 1'b1, rsv, 5'h0, h[8:1]});
         $display("test round %0d done", r);
      end
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(OFS_FEN, FEN_RST);
      $display("test second reset done");
      repeat (4) @(posedge clk_i);
      stop_test();
   end
endmodule
bind can_rx_acceptance_filter can_filt_monitor mon_i(.clk_i(clk_i), .rst_i(rst_i),
   .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .msg_valid_i(msg_valid_i),
   .hit_valid_o(hit_valid_o), .hit_accept_o(hit_accept_o), .hit_filter_o(hit_filter_o),
   .hit_buffer_o(hit_buffer_o), .hit_fifo_o(hit_fifo_o));
`default_nettype wire
